// file: shsc_pkg.sv
// Package for the standby halt/stop controller: offsets, fields,
// operand codes, vectors, state and carrier types.
// Assumes one clock domain and a 32-bit AHB-Lite register port.
package shsc_pkg;

  //////////////////////////////////////////////////////////////////////
  // Register map (byte addresses, one aligned word each)
  localparam logic [7:0]  SHSC_OFS_IEN    = 8'h00; // Source enables
  localparam logic [7:0]  SHSC_OFS_KEYCFG = 8'h04; // Key pin setup
  localparam logic [7:0]  SHSC_OFS_STATUS = 8'h08; // Read-only state
  localparam logic [31:0] SHSC_RD_ZERO    = 32'h0000_0000;

  // Enable and request bit positions (priority order)
  localparam int SHSC_SRC_TM8 = 0; // 8-bit timer
  localparam int SHSC_SRC_EXT = 1; // External pin
  localparam int SHSC_SRC_ITV = 2; // Interval timer
  localparam int SHSC_NSRC    = 3;
  localparam logic [2:0] SHSC_IEN_RST = 3'h0;

  // Key configuration fields
  localparam int SHSC_KC_BCD_LSB = 0;  // 12 input masks, B/C/D
  localparam int SHSC_KC_E_LSB   = 12; // 4 input masks, E group
  localparam int SHSC_KC_P1_LSB  = 16; // 4 input masks, second set
  localparam int SHSC_KC_MATRIX  = 20; // Key matrix operation
  localparam int SHSC_KC_SCLVL   = 21; // Set-clear level
  localparam int SHSC_KC_W       = 22;
  localparam logic [21:0] SHSC_KC_RST = 22'h00_0000;

  // Status fields
  localparam int SHSC_ST_STATE = 0;  // Two bits of state
  localparam int SHSC_ST_GIE   = 2;  // Global enable
  localparam int SHSC_ST_VEC   = 3;  // Last wake vectored
  localparam int SHSC_ST_KEY   = 4;  // Last wake by key pin

  // Pin group widths
  localparam int SHSC_PA_W   = 4;
  localparam int SHSC_PBCD_W = 12;
  localparam int SHSC_PE_W   = 4;
  localparam int SHSC_P1_W   = 4;
  localparam int SHSC_PIN_W  = 24;

  // Operand codes of the halt and stop instructions
  localparam logic [3:0] SHSC_OPD_TIMER = 4'h2;
  localparam logic [3:0] SHSC_OPD_KEY   = 4'h8;

  // Vector addresses
  localparam logic [15:0] SHSC_VEC_TM8 = 16'h0004;
  localparam logic [15:0] SHSC_VEC_EXT = 16'h0003;
  localparam logic [15:0] SHSC_VEC_ITV = 16'h0002;
  localparam logic [15:0] SHSC_VEC_NONE = 16'h0000;

  // Instruction kinds from the sequencer
  typedef enum logic [2:0] {
    SHSC_OP_NONE, SHSC_OP_HALT, SHSC_OP_STOP,
    SHSC_OP_EI, SHSC_OP_DI
  } shsc_op_t;

  // Controller state
  typedef enum logic [1:0] {
    SHSC_RUN, SHSC_HALT_TM, SHSC_HALT_KEY, SHSC_STOP
  } shsc_state_t;

  // Instruction carrier
  typedef struct packed {
    logic       valid;
    shsc_op_t   op;
    logic [3:0] operand;
  } shsc_instr_t;

  // Wake carrier
  typedef struct packed {
    logic        resume;
    logic        vector;
    logic [15:0] addr;
  } shsc_wake_t;

endpackage

// file: shsc_sync2.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the pins are quasi-static levels; bits are not coherent.
`timescale 1ns/10ps
module shsc_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // First stage, read only by the second
  logic [WIDTH-1:0] meta_ff;

  // Reset to ones: idle keys read high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff  <= '1;
      sync_out <= '1;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// file: shsc_standby_ctrl.sv
// Standby controller: halt and stop entry, guards, wake and vectoring.
// Assumes the sequencer issues one instruction pulse at a time on hclk,
// request flags come from same-clock logic, key pins are asynchronous.
//
// Function
// - Halt freezes core, clock keeps running
// - Stop gates clock off until release
// - Only halt/stop instructions enter standby
// - Halt 02H ends on timer request
// - Halt 08H ends on enabled request
// - Halt 08H ends on low key pin
// - Matrix mode: low E-group pin wakes
// - Matrix mode: second set at level wakes
// - Pin wake resumes at next instruction
// - Disabled source never ends halt 08H
// - Both enables set: branch to vector
// - Timer always ends 02H; vectors if enabled
// - Guard fails: instruction is no-op
// - Halt 02H needs timer request clear
// - Halt 08H needs enabled requests clear
// - Halt 08H needs all enabled key pins idle
// - Global enable: EI sets, DI clears
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module shsc_standby_ctrl
  import shsc_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire shsc_instr_t           instr,
  input  wire logic [SHSC_NSRC-1:0]  int_request,
  input  wire logic [SHSC_PIN_W-1:0] key_pins,
  output logic                       core_freeze,
  output logic                       system_clock_en,
  output logic                       no_operation,
  output shsc_wake_t                 wake
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [SHSC_PIN_W-1:0] pins_s;   // Synchronised key levels

  shsc_sync2 #(.WIDTH(SHSC_PIN_W)) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (key_pins),
    .sync_out (pins_s)
  );

  ////////////////////////////////////////////////////////////////////
  // Register bus slave, zero wait states
  logic [2:0]          ien_ff;     // Per-source enables
  logic [SHSC_KC_W-1:0] kcfg_ff;   // Key configuration
  logic                 wr_ff;     // Write pending in data phase
  logic [7:0]           wa_ff;     // Its byte address
  logic [31:0]          rd_ff;     // Read word for data phase
  logic [31:0]          status_w;  // Live status word
  logic                 acc_w;     // Address phase accepted
  logic [31:0]          rd_w;      // Decoded read word
  logic [7:0]           a_w;       // Low address byte

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rd_ff;
  assign acc_w     = hsel && hready && htrans[1];
  assign a_w       = haddr[7:0];

  // Read decode; unmapped addresses read zero
  always_comb begin
    if (a_w == SHSC_OFS_IEN) begin
      rd_w = {29'h0, ien_ff};
    end else if (a_w == SHSC_OFS_KEYCFG) begin
      rd_w = {10'h0, kcfg_ff};
    end else if (a_w == SHSC_OFS_STATUS) begin
      rd_w = status_w;
    end else begin
      rd_w = SHSC_RD_ZERO;
    end
  end

  // Address phase capture; read data ready for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= 8'h00;
      rd_ff <= SHSC_RD_ZERO;
    end else begin
      wr_ff <= acc_w && hwrite;
      wa_ff <= a_w;
      rd_ff <= (acc_w && !hwrite) ? rd_w : SHSC_RD_ZERO;
    end
  end

  // Data phase write; unmapped writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_ff  <= SHSC_IEN_RST;
      kcfg_ff <= SHSC_KC_RST;
    end else if (wr_ff) begin
      if (wa_ff == SHSC_OFS_IEN) begin
        ien_ff <= hwdata[SHSC_NSRC-1:0];
      end else if (wa_ff == SHSC_OFS_KEYCFG) begin
        kcfg_ff <= hwdata[SHSC_KC_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Key pin wake terms
  logic [SHSC_PA_W-1:0]   pa_s;    // Always-input group
  logic [SHSC_PBCD_W-1:0] pbcd_s;  // Groups B, C, D
  logic [SHSC_PE_W-1:0]   pe_s;    // Scan group E
  logic [SHSC_P1_W-1:0]   p1_s;    // Second port set
  logic                   matrix_w; // Key matrix operation
  logic [SHSC_P1_W-1:0]   scl_w;   // Set-clear level, spread
  logic pa_low, pbcd_low, pe_low, p1_hit, key_wake;

  assign {p1_s, pe_s, pbcd_s, pa_s} = pins_s;
  assign matrix_w = kcfg_ff[SHSC_KC_MATRIX];
  assign scl_w    = {SHSC_P1_W{kcfg_ff[SHSC_KC_SCLVL]}};

  assign pa_low   = |(~pa_s);
  assign pbcd_low =
    |(~pbcd_s & kcfg_ff[SHSC_KC_BCD_LSB +: SHSC_PBCD_W]);
  assign pe_low   = matrix_w &&
    |(~pe_s & kcfg_ff[SHSC_KC_E_LSB +: SHSC_PE_W]);
  assign p1_hit   = matrix_w &&
    |(~(p1_s ^ scl_w) & kcfg_ff[SHSC_KC_P1_LSB +: SHSC_P1_W]);
  assign key_wake = pa_low || pbcd_low || pe_low || p1_hit;

  ////////////////////////////////////////////////////////////////////
  // Request terms and vector choice
  logic                 gie_ff;   // Global interrupt enable
  logic [SHSC_NSRC-1:0] en_req;   // Requests of enabled sources
  logic                 tm_req;   // Timer request alone

  assign en_req = int_request & ien_ff;
  assign tm_req = int_request[SHSC_SRC_TM8];

  // Highest-priority vector among requests; timer first
  function automatic logic [15:0] pick_vec(
    input logic [SHSC_NSRC-1:0] req
  );
    logic [15:0] v;
    v = SHSC_VEC_NONE;
    if (req[SHSC_SRC_TM8]) begin
      v = SHSC_VEC_TM8;
    end else if (req[SHSC_SRC_EXT]) begin
      v = SHSC_VEC_EXT;
    end else if (req[SHSC_SRC_ITV]) begin
      v = SHSC_VEC_ITV;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Instruction decode and execution guards
  logic halt_cmd, stop_cmd, ok_tm, ok_key, go_tm, go_key, go_stop;

  assign halt_cmd = instr.valid && instr.op == SHSC_OP_HALT;
  assign stop_cmd = instr.valid && instr.op == SHSC_OP_STOP;
  assign ok_tm  = !tm_req;
  assign ok_key = !(|en_req) && !key_wake;
  // Other operands are prohibited and never enter standby
  assign go_tm   = halt_cmd && instr.operand == SHSC_OPD_TIMER && ok_tm;
  assign go_key  = halt_cmd && instr.operand == SHSC_OPD_KEY && ok_key;
  assign go_stop = stop_cmd && instr.operand == SHSC_OPD_KEY && ok_key;

  ////////////////////////////////////////////////////////////////////
  // State machine
  shsc_state_t state_ff, nxt_state;
  logic        nxt_resume, nxt_vector, nxt_nop;
  logic [15:0] nxt_addr;
  logic        rel_key;   // Wake condition for key operand

  assign rel_key = key_wake || (|en_req);

  always_comb begin
    nxt_state  = state_ff;
    nxt_resume = 1'b0;
    nxt_vector = 1'b0;
    nxt_nop    = 1'b0;
    nxt_addr   = SHSC_VEC_NONE;
    case (state_ff)
      SHSC_RUN: begin
        if (go_tm) begin
          nxt_state = SHSC_HALT_TM;
        end else if (go_key) begin
          nxt_state = SHSC_HALT_KEY;
        end else if (go_stop) begin
          nxt_state = SHSC_STOP;
        end else if (halt_cmd || stop_cmd) begin
          nxt_nop = 1'b1;
        end
      end
      SHSC_HALT_TM: begin
        if (tm_req) begin
          nxt_state = SHSC_RUN;
          if (gie_ff && ien_ff[SHSC_SRC_TM8]) begin
            nxt_vector = 1'b1;
            nxt_addr   = SHSC_VEC_TM8;
          end else begin
            nxt_resume = 1'b1;
          end
        end
      end
      default: begin
        if (rel_key) begin
          nxt_state = SHSC_RUN;
          if (gie_ff && |en_req) begin
            nxt_vector = 1'b1;
            nxt_addr   = pick_vec(en_req);
          end else begin
            nxt_resume = 1'b1;
          end
        end
      end
    endcase
  end

  // State and registered outputs
  logic last_vec_ff, last_key_ff;  // Cause of the last wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= SHSC_RUN;
      wake         <= '0;
      no_operation <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      wake.resume  <= nxt_resume;
      wake.vector  <= nxt_vector;
      wake.addr    <= nxt_addr;
      no_operation <= nxt_nop;
    end
  end

  // freeze core, gate clock in stop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      core_freeze     <= 1'b0;
      system_clock_en <= 1'b1;
    end else begin
      core_freeze     <= nxt_state != SHSC_RUN;
      system_clock_en <= nxt_state != SHSC_STOP;
    end
  end

  // Wake cause record for software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_vec_ff <= 1'b0;
      last_key_ff <= 1'b0;
    end else if (nxt_resume || nxt_vector) begin
      last_vec_ff <= nxt_vector;
      last_key_ff <= key_wake && state_ff != SHSC_HALT_TM;
    end
  end

  // EI sets, DI and vectoring clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gie_ff <= 1'b0;
    end else if (nxt_vector) begin
      gie_ff <= 1'b0;
    end else if (instr.valid && instr.op == SHSC_OP_EI) begin
      gie_ff <= 1'b1;
    end else if (instr.valid && instr.op == SHSC_OP_DI) begin
      gie_ff <= 1'b0;
    end
  end

  assign status_w = {27'h0, last_key_ff, last_vec_ff, gie_ff,
                     state_ff};

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_halt_tm;
    state_ff == SHSC_HALT_TM && tm_req;
  endsequence
  sequence s_out_vec(logic [15:0] a);
    wake.vector && !wake.resume && wake.addr == a;
  endsequence

  AST_FREEZE_WITH_CLOCK: assert property (
    state_ff inside {SHSC_HALT_TM, SHSC_HALT_KEY}
      |-> core_freeze && system_clock_en)
    else $error("halt state without freeze or clock");
  AST_STOP_GATES: assert property (
    state_ff == SHSC_STOP |-> !system_clock_en && core_freeze)
    else $error("stop state with clock running");
  AST_ENTRY_BY_INSTR: assert property (
    $rose(core_freeze) |-> $past(halt_cmd || stop_cmd))
    else $error("standby entered without instruction");
  AST_TM_RELEASE: assert property (
    s_halt_tm |=> !core_freeze && (wake.resume ^ wake.vector))
    else $error("timer request did not end halt");
  AST_TM_VECTOR: assert property (
    s_halt_tm and (gie_ff && ien_ff[SHSC_SRC_TM8])
      |=> s_out_vec(SHSC_VEC_TM8))
    else $error("timer wake did not vector");
  AST_DISABLED_HOLDS: assert property (
    state_ff == SHSC_HALT_KEY && !key_wake && !(|en_req)
      |=> core_freeze)
    else $error("halt ended without a valid cause");
  AST_KEY_RESUME: assert property (
    state_ff == SHSC_HALT_KEY && key_wake && !(|en_req)
      |=> wake.resume && !wake.vector && !core_freeze)
    else $error("pin wake did not resume");
  AST_GUARD_NOP: assert property (
    state_ff == SHSC_RUN && halt_cmd && !go_tm && !go_key
      |=> no_operation && !core_freeze)
    else $error("failed guard did not act as no-op");
  AST_TM_GUARD: assert property (
    state_ff == SHSC_RUN && halt_cmd && tm_req
      |=> state_ff != SHSC_HALT_TM)
    else $error("halt entered with timer flag set");
  AST_GIE_EI: assert property (
    instr.valid && instr.op == SHSC_OP_EI && !nxt_vector
      |=> gie_ff)
    else $error("EI did not set global enable");
  AST_GIE_DI: assert property (
    instr.valid && instr.op == SHSC_OP_DI |=> !gie_ff)
    else $error("DI did not clear global enable");

endmodule

// file: shsc_seq_model.sv
// Far-side model: instruction sequencer, request flags and key pins.
// Assumes one clock; the bench calls its tasks by hierarchical name.
`timescale 1ns/10ps
module shsc_seq_model
  import shsc_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             core_freeze,
  output shsc_instr_t           instr,
  output logic [SHSC_NSRC-1:0]  int_request,
  output logic [SHSC_PIN_W-1:0] key_pins
);
  ////////////////////////////////////////////////////////////////////
  // Idle levels: no instruction, flags clear, pins pulled high
  initial begin
    instr       = '0;
    int_request = '0;
    key_pins    = '1;
  end

  ////////////////////////////////////////////////////////////////////
  // One instruction pulse; a frozen core issues nothing
  // spare edge after flag change
  task automatic issue(input shsc_op_t op, input logic [3:0] opd);
    while (core_freeze === 1'b1) @(posedge hclk);
    @(posedge hclk);
    instr <= '{1'b1, op, opd};
    @(posedge hclk);
    instr <= '0;
  endtask

  // Request flag levels, changed just after an edge
  task automatic set_req(input logic [SHSC_NSRC-1:0] v);
    @(posedge hclk);
    int_request <= v;
  endtask

  // Key pin levels, asynchronous to the core in the real part
  task automatic set_pins(input logic [SHSC_PIN_W-1:0] v);
    @(posedge hclk);
    key_pins <= v;
  endtask
endmodule

// file: shsc_standby_ctrl_bench.sv
// Self-checking bench for the standby controller.
// Assumes one slave on the bus, so hready is the slave's hreadyout.
`timescale 1ns/10ps
module shsc_standby_ctrl_bench
  import shsc_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite;     // Bus and clock
  logic [31:0] haddr, hwdata, hrdata, rd;       // Address and data
  logic [1:0]  htrans;                          // Transfer kind
  logic [2:0]  hsize;                           // A word in each address phase
  logic        hreadyout, hresp;                // Slave answer
  shsc_instr_t instr;                           // From sequencer
  logic [2:0]  int_request;                     // Flag levels
  logic [23:0] key_pins;                        // Pin levels
  logic        core_freeze, system_clock_en;    // Standby outputs
  logic        no_operation;                    // Guard failed
  shsc_wake_t  wake;                            // Wake pulses
  int          failures, checks, cycles;        // Run counters

  // Interrupt wake cases: operand, gie, enables, flags, vectored
  typedef struct packed {
    logic [3:0] opd; logic gie; logic [2:0] ien; logic [2:0] req;
    logic vec; logic [15:0] addr;
  } shsc_icase_t;
  shsc_icase_t icase [6] = '{
    '{4'h2, 1'b0, 3'h0, 3'h1, 1'b0, SHSC_VEC_NONE},
    '{4'h2, 1'b1, 3'h1, 3'h1, 1'b1, SHSC_VEC_TM8},
    '{4'h8, 1'b0, 3'h2, 3'h2, 1'b0, SHSC_VEC_NONE},
    '{4'h8, 1'b1, 3'h2, 3'h2, 1'b1, SHSC_VEC_EXT},
    '{4'h8, 1'b1, 3'h4, 3'h4, 1'b1, SHSC_VEC_ITV},
    '{4'h8, 1'b1, 3'h7, 3'h7, 1'b1, SHSC_VEC_TM8}};
  // Key cases: config word, idle levels, waking levels
  logic [31:0] kcfg  [4] = '{32'h0, 32'h1, 32'h0010_f000, 32'h003f_0000};
  logic [23:0] kidle [4] = '{24'hff_ffff, 24'hff_ffff, 24'hff_ffff,
                             24'h0f_ffff};
  logic [23:0] kwake [4] = '{24'hff_fffe, 24'hff_ffef, 24'hfe_ffff,
                             24'h1f_ffff};
  // Refused operand cases
  shsc_op_t    bop  [3] = '{SHSC_OP_HALT, SHSC_OP_HALT, SHSC_OP_STOP};
  logic [3:0]  bopd [3] = '{4'h3, 4'h0, SHSC_OPD_TIMER};

  ////////////////////////////////////////////////////////////////////
  shsc_standby_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .instr(instr), .int_request(int_request),
    .key_pins(key_pins), .core_freeze(core_freeze),
    .system_clock_en(system_clock_en), .no_operation(no_operation),
    .wake(wake));

  shsc_seq_model m (
    .hclk(hclk), .core_freeze(core_freeze), .instr(instr),
    .int_request(int_request), .key_pins(key_pins));

  ////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Watchdog: the whole sequence needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Single compare for every kind of result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One single word transfer; waits on hready, never on a count
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rv);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    hsize  <= 3'b000;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Issue and look just after the taking edge has landed
  task automatic do_op(input shsc_op_t op, input logic [3:0] opd);
    m.issue(op, opd);
    #1;
  endtask

  // Bounded wait for release; pulses are seen in their one cycle
  task automatic wait_wake(input logic [17:0] e);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (core_freeze === 1'b1 && n < 20);
    chk({31'h0, core_freeze}, 32'h0);
    chk({14'h0, wake}, {14'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsize = 3'b000;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped and read-only places
    rd_chk(SHSC_OFS_STATUS, 32'h0);
    rd_chk(SHSC_OFS_IEN, {29'h0, SHSC_IEN_RST});
    rd_chk(SHSC_OFS_KEYCFG, {10'h0, SHSC_KC_RST});
    wr_reg(8'h0c, 32'hffff_ffff);
    rd_chk(8'h0c, SHSC_RD_ZERO);
    wr_reg(SHSC_OFS_STATUS, 32'hff);
    rd_chk(SHSC_OFS_STATUS, 32'h0);
    // Global enable set and cleared, no standby entered
    do_op(SHSC_OP_EI, 4'h0);
    chk({30'h0, core_freeze, no_operation}, 32'h0);
    rd_chk(SHSC_OFS_STATUS, 32'h4);
    do_op(SHSC_OP_DI, 4'h0);
    rd_chk(SHSC_OFS_STATUS, 32'h0);
    // Pending flags or refused operands turn halt and stop into a no-op
    m.set_req(3'h1);
    do_op(SHSC_OP_HALT, SHSC_OPD_TIMER);
    chk({30'h0, core_freeze, no_operation}, 32'h1);
    wr_reg(SHSC_OFS_IEN, 32'h1);
    do_op(SHSC_OP_HALT, SHSC_OPD_KEY);
    chk({30'h0, core_freeze, no_operation}, 32'h1);
    m.set_req(3'h0);
    foreach (bop[i]) begin
      do_op(bop[i], bopd[i]);
      chk({30'h0, core_freeze, no_operation}, 32'h1);
    end
    // Disabled sources keep halt 08H, enabled one ends it
    wr_reg(SHSC_OFS_IEN, 32'h2);
    do_op(SHSC_OP_HALT, SHSC_OPD_KEY);
    m.set_req(3'h5);
    repeat (6) @(posedge hclk);
    #1;
    chk({30'h0, core_freeze, wake.resume}, 32'h2);
    m.set_req(3'h7);
    wait_wake({1'b1, 1'b0, SHSC_VEC_NONE});
    m.set_req(3'h0);
    // Request wake: resume or vector, priority, enable cleared
    foreach (icase[i]) begin
      wr_reg(SHSC_OFS_IEN, {29'h0, icase[i].ien});
      do_op(icase[i].gie ? SHSC_OP_EI : SHSC_OP_DI, 4'h0);
      do_op(SHSC_OP_HALT, icase[i].opd);
      chk({30'h0, core_freeze, system_clock_en}, 32'h3);
      m.set_req(icase[i].req);
      wait_wake({~icase[i].vec, icase[i].vec, icase[i].addr});
      m.set_req(3'h0);
      rd_chk(SHSC_OFS_STATUS, {28'h0, icase[i].vec,
             icase[i].gie & ~icase[i].vec, 2'h0});
    end
    // Key wake ignores both enables; last case uses stop
    do_op(SHSC_OP_EI, 4'h0);
    wr_reg(SHSC_OFS_IEN, 32'h7);
    foreach (kcfg[i]) begin
      wr_reg(SHSC_OFS_KEYCFG, kcfg[i]);
      m.set_pins(kwake[i]);
      repeat (3) @(posedge hclk);
      do_op(SHSC_OP_HALT, SHSC_OPD_KEY);
      chk({30'h0, core_freeze, no_operation}, 32'h1);
      m.set_pins(kidle[i]);
      repeat (3) @(posedge hclk);
      do_op(i == 3 ? SHSC_OP_STOP : SHSC_OP_HALT, SHSC_OPD_KEY);
      chk({30'h0, core_freeze, system_clock_en},
          i == 3 ? 32'h2 : 32'h3);
      m.set_pins(kwake[i]);
      wait_wake({1'b1, 1'b0, SHSC_VEC_NONE});
      chk({31'h0, system_clock_en}, 32'h1);
      rd_chk(SHSC_OFS_STATUS, 32'h14);
    end
    // Reset in mid-halt: standby left, state and config cleared
    m.set_pins(kidle[3]);
    repeat (3) @(posedge hclk);
    do_op(SHSC_OP_HALT, SHSC_OPD_KEY);
    chk({31'h0, core_freeze}, 32'h1);
    @(posedge hclk);
    hresetn <= 1'b0;
    #1;
    chk({29'h0, core_freeze, system_clock_en, no_operation}, 32'h2);
    chk({14'h0, wake}, 32'h0);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(SHSC_OFS_STATUS, 32'h0);
    rd_chk(SHSC_OFS_KEYCFG, {10'h0, SHSC_KC_RST});
    close_out();
  end
endmodule
